// [can_filter_routing_ctrl.sv]
// acceptance filter control registers, compare and buffer routing
`timescale 1ns/1ps
`include "can_filt_defs.svh"
module can_filter_routing_ctrl
    import can_filt_pkg::*;
#(
    parameter int NUM_FILTERS = 16,
    parameter int NUM_MASKS   = 4
) (
    // clock and reset
    input  wire logic                    i_clk,
    input  wire logic                    i_rst,
    // wishbone slave
    input  wire logic                    i_wb_cyc,
    input  wire logic                    i_wb_stb,
    input  wire logic                    i_wb_we,
    input  wire logic [7:0]              i_wb_adr,
    input  wire logic [31:0]             i_wb_dat,
    input  wire logic [3:0]              i_wb_sel,
    output logic                         o_wb_ack,
    output logic [31:0]                  o_wb_dat,
    // control bytes of filters 0 to 11, same layout as group three
    input  wire logic [95:0]             i_low_ctrl,
    // acceptance masks, mask k at bits 29k+28:29k
    input  wire logic [NUM_MASKS*29-1:0] i_masks,
    // received identifier
    input  wire logic                    i_rx_valid,
    input  wire logic [28:0]             i_rx_id,
    input  wire logic                    i_rx_ext,
    // routing result
    output logic                         o_match_valid,
    output logic                         o_reject,
    output logic [3:0]                   o_match_filter,
    output logic [4:0]                   o_match_fifo
);
    filt_state_t      state_q;
    filt_state_t      state_d;
    logic [15:0][7:0] ctrl_byte;
    logic [15:0]      active;
    logic [15:0]      hit;
    logic [3:0]       win;
    logic [3:0]       pidx;
    logic             any_hit;
    logic             req_new;
    logic             wr_commit;
    logic             is_pat;
    logic [31:0]      rd_word;

    if (NUM_FILTERS != 16 || NUM_MASKS != 4) begin : g_chk
        $error("can_filter_routing_ctrl: map fixed at 16 filters, 4 masks");
    end

    function automatic logic [31:0] merge(input logic [31:0] old_v,
                                          input logic [31:0] new_v,
                                          input logic [3:0]  sel);
        logic [31:0] r;
        r = old_v;
        for (int b = 0; b < 4; b++) begin
            if (sel[b]) begin
                r[b*8 +: 8] = new_v[b*8 +: 8];
            end
        end
        return r;
    endfunction

    // filter 15 sits in the top byte, filter 12 in the bottom one
    assign ctrl_byte = {state_q.ctrl, i_low_ctrl};

    for (genvar g = 0; g < 16; g++) begin : g_flt
        assign active[g] = ctrl_byte[g][`CF_EN_BIT];
        filter_match #(
            .NUM_MASKS (NUM_MASKS),
            .ID_W      (29)
        ) u_match (
            .i_active      (active[g]),
            .i_mask_choice (mask_sel_t'(ctrl_byte[g][`CF_CHOICE_LSB +: 2])),
            .i_pattern     (state_q.pat[g]),
            .i_masks       (i_masks),
            .i_rx_id       (i_rx_id),
            .i_rx_ext      (i_rx_ext),
            .o_hit         (hit[g])
        );
    end

    // lowest numbered filter wins when several match
    always_comb begin
        win = 4'h0;
        for (int n = 15; n >= 0; n--) begin
            if (hit[n]) begin
                win = 4'(n);
            end
        end
    end

    assign any_hit   = |hit;
    assign req_new   = i_wb_cyc & i_wb_stb & ~state_q.ack;
    assign wr_commit = i_wb_cyc & i_wb_stb & state_q.ack & i_wb_we;
    assign is_pat    = (i_wb_adr & `CF_OFS_PAT_MASK) == `CF_OFS_PAT_BASE;
    assign pidx      = i_wb_adr[5:2];

    always_comb begin
        rd_word = 32'h0000_0000;
        if (is_pat) begin
            rd_word = state_q.pat[pidx];
        end else if (i_wb_adr == `CF_OFS_CTRL) begin
            rd_word = state_q.ctrl;
        end else if (i_wb_adr == `CF_OFS_STAT) begin
            rd_word[`CF_ST_FILT_LSB +: 4] = state_q.last_filt;
            rd_word[`CF_ST_FIFO_LSB +: 5] = state_q.last_fifo;
            rd_word[`CF_ST_SEEN_BIT]      = state_q.seen;
        end
    end

    always_comb begin
        state_d        = state_q;
        state_d.ack    = req_new;
        state_d.rdat   = 32'h0000_0000;
        state_d.mvalid = 1'b0;
        state_d.reject = 1'b0;
        if (req_new && !i_wb_we) begin
            state_d.rdat = rd_word;
        end
        // writes land on the edge that the master samples ack
        if (wr_commit) begin
            if (i_wb_adr == `CF_OFS_CTRL) begin
                state_d.ctrl = merge(state_q.ctrl, i_wb_dat, i_wb_sel);
            end else if (is_pat && !active[pidx]) begin
                // an enabled filter keeps its pattern so a match
                // never sees a half written identifier
                state_d.pat[pidx] = merge(state_q.pat[pidx], i_wb_dat,
                                          i_wb_sel) & `CF_PAT_RW_MASK;
            end
        end
        if (i_rx_valid) begin
            if (any_hit) begin
                state_d.mvalid    = 1'b1;
                state_d.mfilt     = win;
                state_d.mfifo     = ctrl_byte[win][`CF_DEST_LSB +: 5];
                state_d.last_filt = win;
                state_d.last_fifo = ctrl_byte[win][`CF_DEST_LSB +: 5];
                state_d.seen      = 1'b1;
            end else begin
                state_d.reject = 1'b1;
            end
        end
    end

    always_ff @(posedge i_clk or posedge i_rst) begin
        if (i_rst) begin
            state_q           <= '0;
            state_q.ctrl      <= `CF_CTRL_RST;
            state_q.pat       <= {16{`CF_PAT_RST}};
        end else begin
            state_q <= state_d;
        end
    end

    assign o_wb_ack       = state_q.ack;
    assign o_wb_dat       = state_q.rdat;
    assign o_match_valid  = state_q.mvalid;
    assign o_reject       = state_q.reject;
    assign o_match_filter = state_q.mfilt;
    assign o_match_fifo   = state_q.mfifo;

    default clocking cb @(posedge i_clk); endclocking
    default disable iff (i_rst);

    a_en13_write: assert property (
        wr_commit && i_wb_adr == `CF_OFS_CTRL && i_wb_sel[1]
        |=> active[13] == $past(i_wb_dat[15]))
        else $error("filter 13 enable did not follow write");

    a_en12_write: assert property (
        wr_commit && i_wb_adr == `CF_OFS_CTRL && i_wb_sel[0]
        |=> active[12] == $past(i_wb_dat[7]))
        else $error("filter 12 enable did not follow write");

    a_mask_choice13: assert property (
        i_rx_valid && hit[13] |-> ~|(({state_q.pat[13][31:21],
            state_q.pat[13][17:0]} ^ i_rx_id)
            & i_masks[int'(state_q.ctrl[14:13])*29 +: 29]
            & {11'h7FF, {18{i_rx_ext}}}))
        else $error("filter 13 matched outside its chosen mask");

    a_mask_choice12: assert property (
        i_rx_valid && hit[12] |-> ~|(({state_q.pat[12][31:21],
            state_q.pat[12][17:0]} ^ i_rx_id)
            & i_masks[int'(state_q.ctrl[6:5])*29 +: 29]
            & {11'h7FF, {18{i_rx_ext}}}))
        else $error("filter 12 matched outside its chosen mask");

    a_fifo_route: assert property (
        i_rx_valid && any_hit |=> o_match_valid
        && o_match_fifo == $past(ctrl_byte[win][4:0]))
        else $error("match routed to wrong buffer");

    a_fifo14_route: assert property (
        i_rx_valid && hit[14] && hit[13:0] == 14'h0000
        |=> o_match_filter == 4'hE
        && o_match_fifo == $past(state_q.ctrl[20:16]))
        else $error("filter 14 buffer field not used");

    a_pat_store: assert property (
        wr_commit && is_pat && !active[pidx] && i_wb_sel == 4'hF
        |=> state_q.pat[$past(pidx)]
            == ($past(i_wb_dat) & `CF_PAT_RW_MASK))
        else $error("pattern register did not store write");

    a_ext_format: assert property (
        i_rx_valid && any_hit
        |-> state_q.pat[win][`CF_EXT_SEL_BIT] == i_rx_ext)
        else $error("match across frame formats");

    a_locked_pat: assert property (
        wr_commit && is_pat && active[pidx]
        |=> state_q.pat[$past(pidx)] == $past(state_q.pat[pidx]))
        else $error("enabled filter pattern was overwritten");

    a_off_silent: assert property (
        i_rx_valid && active == 16'h0000 |=> o_reject && !o_match_valid)
        else $error("disabled filters produced a match");

    c_match13: cover property (i_rx_valid && any_hit && win == 4'hD);
    c_reject: cover property (i_rx_valid && !any_hit);
    c_locked: cover property (wr_commit && is_pat && active[pidx]);
endmodule // can_filter_routing_ctrl

// [can_filt_defs.svh]
// register map, field positions and reset values of the filter control block
// Function
// - filter 13 enable at control bit 15
// - filter 12 enable at control bit 7
// - filter 13 mask choice, bits 14:13
// - filter 12 mask choice, bits 6:5
// - match stored in selected buffer 0-31
// - buffer fields at 20:16, 12:8, 4:0
// - sixteen acceptance pattern registers, index 0-15
// - unmasked pattern bits must equal identifier
// - bit 19 picks extended or standard format
`ifndef CAN_FILT_DEFS_SVH
`define CAN_FILT_DEFS_SVH

// word offsets on the bus
`define CF_OFS_CTRL      8'h00
`define CF_OFS_STAT      8'h04
`define CF_OFS_PAT_BASE  8'h40
`define CF_OFS_PAT_MASK  8'hC0

// per-filter control byte layout
`define CF_EN_BIT        7
`define CF_CHOICE_LSB    5
`define CF_DEST_LSB      0

// acceptance pattern layout
`define CF_STD_PAT_LSB   21
`define CF_EXT_SEL_BIT   19
`define CF_EXT_PAT_MSB   17
`define CF_PAT_RW_MASK   32'hFFEB_FFFF

// status layout
`define CF_ST_FILT_LSB   0
`define CF_ST_FIFO_LSB   8
`define CF_ST_SEEN_BIT   16

// reset values
`define CF_CTRL_RST      32'h0000_0000
`define CF_PAT_RST       32'h0000_0000

`endif

// [can_filt_pkg.sv]
// types shared by the acceptance filter control block
package can_filt_pkg;

    typedef enum logic [1:0] {
        MASK_0 = 2'b00,
        MASK_1 = 2'b01,
        MASK_2 = 2'b10,
        MASK_3 = 2'b11
    } mask_sel_t;

    typedef struct packed {
        logic [31:0]       ctrl;
        logic [15:0][31:0] pat;
        logic              ack;
        logic [31:0]       rdat;
        logic              mvalid;
        logic              reject;
        logic [3:0]        mfilt;
        logic [4:0]        mfifo;
        logic [3:0]        last_filt;
        logic [4:0]        last_fifo;
        logic              seen;
    } filt_state_t;

endpackage

// [filter_match.sv]
// one acceptance filter compare against the received identifier
`timescale 1ns/1ps
`include "can_filt_defs.svh"
module filter_match
    import can_filt_pkg::*;
#(
    parameter int NUM_MASKS = 4,
    parameter int ID_W      = 29
) (
    // filter setup
    input  wire logic                      i_active,
    input  wire mask_sel_t                 i_mask_choice,
    input  wire logic [31:0]               i_pattern,
    input  wire logic [NUM_MASKS*ID_W-1:0] i_masks,
    // received frame
    input  wire logic [ID_W-1:0]           i_rx_id,
    input  wire logic                      i_rx_ext,
    // result
    output logic                           o_hit
);
    logic [ID_W-1:0] want;
    logic [ID_W-1:0] mask;
    logic [ID_W-1:0] used;

    if (NUM_MASKS != 4 || ID_W != 29) begin : g_chk
        $error("filter_match: two-bit mask choice needs 4 masks of 29 bits");
    end

    assign want = {i_pattern[31:`CF_STD_PAT_LSB],
                   i_pattern[`CF_EXT_PAT_MSB:0]};
    assign mask = i_masks[int'(i_mask_choice)*ID_W +: ID_W];
    // standard frames carry only the upper eleven bits
    assign used = i_rx_ext ? mask : {mask[ID_W-1:ID_W-11], 18'h0_0000};
    assign o_hit = i_active
                 & (i_pattern[`CF_EXT_SEL_BIT] == i_rx_ext)
                 & ~|((want ^ i_rx_id) & used);
endmodule // filter_match

// [can_filter_routing_ctrl_tb.sv]
// self-checking bench for the acceptance filter control block
`timescale 1ns/1ps
module can_filter_routing_ctrl_tb;

    logic          i_clk      = 1'b0;
    logic          i_rst      = 1'b1;
    logic          i_wb_cyc   = 1'b0;
    logic          i_wb_stb   = 1'b0;
    logic          i_wb_we    = 1'b0;
    logic [7:0]    i_wb_adr   = 8'h00;
    logic [31:0]   i_wb_dat   = 32'h0000_0000;
    logic [3:0]    i_wb_sel   = 4'h0;
    logic          i_rx_valid = 1'b0;
    logic [28:0]   i_rx_id    = 29'h0;
    logic          i_rx_ext   = 1'b0;
    logic          o_wb_ack;
    logic [31:0]   o_wb_dat;
    logic          o_match_valid;
    logic          o_reject;
    logic [3:0]    o_match_filter;
    logic [4:0]    o_match_fifo;
    logic [31:0]   rd;
    int            n_errors        = 0;
    int            samples_checked = 0;
    int            cycles          = 0;

    always #2 i_clk = ~i_clk;

    // filters 0..11 stay off so only group three competes
    can_filter_routing_ctrl i_dut (
        .i_clk          (i_clk),
        .i_rst          (i_rst),
        .i_wb_cyc       (i_wb_cyc),
        .i_wb_stb       (i_wb_stb),
        .i_wb_we        (i_wb_we),
        .i_wb_adr       (i_wb_adr),
        .i_wb_dat       (i_wb_dat),
        .i_wb_sel       (i_wb_sel),
        .o_wb_ack       (o_wb_ack),
        .o_wb_dat       (o_wb_dat),
        .i_low_ctrl     (96'h0),
        // mask 2 ignores the lowest id bit so the mask choice is visible
        .i_masks        ({29'h1FFF_FFFF, 29'h1FFF_FFFE,
                          29'h1FFF_FFFF, 29'h0000_0000}),
        .i_rx_valid     (i_rx_valid),
        .i_rx_id        (i_rx_id),
        .i_rx_ext       (i_rx_ext),
        .o_match_valid  (o_match_valid),
        .o_reject       (o_reject),
        .o_match_filter (o_match_filter),
        .o_match_fifo   (o_match_fifo)
    );

    task automatic complete_run;
        $display("errors %0d checks %0d", n_errors, samples_checked);
        if (n_errors == 0 && samples_checked > 0)
            $display("NO MISMATCHES");
        else
            $display("MISMATCHES SEEN");
        $finish;
    endtask

    task automatic fail(input string m);
        n_errors++;
        $display("[FAIL] %0t %s", $time, m);
    endtask

    // request held until ack is sampled, then released
    task automatic wb_xfer(input logic we, input logic [7:0] a,
                           input logic [31:0] d, input logic [3:0] s);
        @(posedge i_clk);
        i_wb_cyc <= 1'b1;
        i_wb_stb <= 1'b1;
        i_wb_we  <= we;
        i_wb_adr <= a;
        i_wb_dat <= d;
        i_wb_sel <= s;
        // only the bench timeout ends a wait for ack
        do begin
            @(posedge i_clk);
        end while (o_wb_ack !== 1'b1);
        rd = o_wb_dat;
        i_wb_cyc <= 1'b0;
        i_wb_stb <= 1'b0;
    endtask

    task automatic cmp_reg(input logic [7:0] a, input logic [31:0] e);
        wb_xfer(1'b0, a, 32'h0000_0000, 4'hF);
        samples_checked++;
        if (rd !== e)
            fail($sformatf("read %h got %h exp %h", a, rd, e));
    endtask

    task automatic cmp_match(input logic [28:0] id, input logic ext,
                             input logic hit, input logic [3:0] f,
                             input logic [4:0] b);
        @(posedge i_clk);
        i_rx_valid <= 1'b1;
        i_rx_id    <= id;
        i_rx_ext   <= ext;
        @(posedge i_clk);
        i_rx_valid <= 1'b0;
        @(posedge i_clk);
        samples_checked++;
        if (o_match_valid !== hit || o_reject !== ~hit ||
            (hit && (o_match_filter !== f || o_match_fifo !== b)))
            fail($sformatf("classify %h gave filter %0d", id, o_match_filter));
    endtask

    always @(posedge i_clk) begin
        cycles++;
        if (cycles == 3000) begin
            fail("timeout");
            complete_run();
        end
    end

    initial begin
        repeat (2) @(posedge i_clk);
        i_rst <= 1'b0;
        cmp_reg(8'h00, 32'h0000_0000);
        cmp_reg(8'h40, 32'h0000_0000);
        for (int n = 0; n < 16; n++) begin
            wb_xfer(1'b1, 8'(8'h40 + 4 * n),
                    32'hFFFF_FFF0 | 32'(n), 4'hF);
            cmp_reg(8'(8'h40 + 4 * n),
                    (32'hFFFF_FFF0 | 32'(n)) & 32'hFFEB_FFFF);
        end
        // every filter still off: nothing may match
        cmp_match({11'h7FF, 18'h0}, 1'b0, 1'b0, 4'h0, 5'h00);
        wb_xfer(1'b1, 8'h70, 32'h2460_0000, 4'hF);
        wb_xfer(1'b1, 8'h74, {11'h3A5, 3'b010, 18'h2_BCDE}, 4'hF);
        wb_xfer(1'b1, 8'h78, 32'hFFE0_0000, 4'hF);
        wb_xfer(1'b1, 8'h00, 32'h00E9_CFA5, 4'hF);
        cmp_reg(8'h00, 32'h00E9_CFA5);
        cmp_match({11'h123, 18'h0}, 1'b0, 1'b1, 4'hC, 5'h05);
        cmp_match({11'h124, 18'h0}, 1'b0, 1'b0, 4'hC, 5'h05);
        cmp_match({11'h3A5, 18'h2_BCDE}, 1'b1, 1'b1, 4'hD, 5'h0F);
        // mask 2 leaves the lowest id bit out of the compare
        cmp_match({11'h3A5, 18'h2_BCDF}, 1'b1, 1'b1, 4'hD, 5'h0F);
        cmp_match({11'h3A5, 18'h2_BCDC}, 1'b1, 1'b0, 4'hD, 5'h0F);
        cmp_match({11'h3A5, 18'h0}, 1'b0, 1'b0, 4'hD, 5'h0F);
        cmp_match({11'h7FF, 18'h0}, 1'b0, 1'b1, 4'hE, 5'h09);
        cmp_reg(8'h04, 32'h0001_090E);
        wb_xfer(1'b1, 8'h70, 32'h0000_0000, 4'hF);
        cmp_reg(8'h70, 32'h2460_0000);
        // byte lane 0 only: filter 12 off, others kept
        wb_xfer(1'b1, 8'h00, 32'hFFFF_FF00, 4'h1);
        cmp_reg(8'h00, 32'h00E9_CF00);
        cmp_match({11'h123, 18'h0}, 1'b0, 1'b0, 4'hE, 5'h09);
        wb_xfer(1'b1, 8'h70, 32'h0000_0000, 4'hF);
        cmp_reg(8'h70, 32'h0000_0000);
        wb_xfer(1'b1, 8'h20, 32'hFFFF_FFFF, 4'hF);
        cmp_reg(8'h20, 32'h0000_0000);
        // a reset in mid-run clears control, status and patterns
        @(posedge i_clk);
        i_rst <= 1'b1;
        repeat (2) @(posedge i_clk);
        i_rst <= 1'b0;
        cmp_reg(8'h00, 32'h0000_0000);
        cmp_reg(8'h04, 32'h0000_0000);
        cmp_reg(8'h74, 32'h0000_0000);
        complete_run();
    end

endmodule // can_filter_routing_ctrl_tb
